/* cst_defs.svh */
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH

// register offsets
`define CST_A_SLOT_LAST 8'h0F
`define CST_A_MODCTL    8'h10
`define CST_A_STATUS    8'h11
`define CST_A_IRQEN     8'h12
`define CST_A_TSTAMP    8'h13

// module control fields
`define CST_MC_LISTEN   0
`define CST_MC_LOOP     1
`define CST_MC_DIV_LO   2
`define CST_MC_DIV_HI   3
`define CST_MC_BERR_EN  4
`define CST_MC_W        5

// status fields
`define CST_ST_MAILBOX_INDEX_HI  3
`define CST_ST_RX_OK    4
`define CST_ST_TX_OK    5
`define CST_ST_RECV     6
`define CST_ST_XMIT     7

// slot control read/write positions
`define CST_SL_FRESH    0
`define CST_SL_UPD      1
`define CST_SL_OVWR     2
`define CST_SL_DONE     3
`define CST_SL_INPROG   4
`define CST_SL_RACT     5
`define CST_SL_HOLD     6
`define CST_SL_REMOTE   7
`define CST_SL_RXREQ    8
`define CST_SL_TXREQ    9

// reset values
`define CST_RST_MODCTL  5'h00
`define CST_RST_IRQEN   16'h0000
`define CST_RST_TS      16'h0000

`endif

/* cst_pkg.sv */
package cst_pkg;

  // one message slot's control state
  typedef struct packed {
    logic tx_request;
    logic rx_request;
    logic remote;
    logic auto_reply_hold;
    logic tx_in_progress;
    logic tx_done_flag;
    logic overwrite_flag;
    logic slot_updating_flag;
    logic slot_fresh_flag;
  } cst_slot_t;

  // event strobes from the protocol engine, one cycle each, except bus_idle, which is a level, and rx_remote and rx_own, which qualify rx_ok
  typedef struct packed {
    logic bit_tick;
    logic sof_seen;
    logic bus_idle;
    logic rx_ok;
    logic rx_remote;
    logic rx_own;
    logic rx_copy_done;
    logic arb_lost;
    logic tx_ok;
    logic err_passive;
    logic bus_off;
    logic bus_err;
    logic wake;
  } cst_evt_t;

  // register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cst_bus_t;

endpackage : cst_pkg

/* cst_timestamp.sv */
`timescale 1ns/1ps
`include "cst_defs.svh"

module cst_timestamp (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        bit_tick,
  input  wire logic [1:0]  div_sel,
  input  wire logic        capture,
  output logic [15:0]      count,
  output logic [15:0]      captured
);

  logic [2:0] pre_q;
  logic [2:0] pre_max;
  logic       ref_tick;

  assign pre_max  = 3'((4'h1 << div_sel) - 4'h1);
  assign ref_tick = bit_tick && (pre_q >= pre_max);

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= 3'h0;
    end else if (bit_tick) begin
      pre_q <= ref_tick ? 3'h0 : 3'(pre_q + 3'h1);
    end
  end

  // free-running, wraps; no stop or preload
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= `CST_RST_TS;
    end else if (ref_tick) begin
      count <= 16'(count + 16'h0001);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      captured <= `CST_RST_TS;
    end else if (capture) begin
      captured <= count;
    end
  end

endmodule : cst_timestamp

/* cst_slot_pick.sv */
`timescale 1ns/1ps

module cst_slot_pick (
  input  wire logic [15:0] req,
  output logic             found,
  output logic [3:0]       idx
);

  // lowest index wins
  always_comb begin
    found = |req;
    idx   = 4'h0;
    for (int j = 15; j >= 0; j--) begin
      if (req[j]) begin
        idx = 4'(j);
      end
    end
  end

endmodule : cst_slot_pick

/* cst_slot_ctrl.sv */
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "cst_defs.svh"

module cst_slot_ctrl (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire cst_pkg::cst_bus_t bus,
  output logic [15:0]            rdata,
  input  wire cst_pkg::cst_evt_t evt,
  input  wire logic [15:0]       accept_match,
  output logic                   tx_start,
  output logic [3:0]             tx_slot,
  output logic                   tx_remote,
  output logic                   drive_enable,
  output logic                   ack_enable,
  output logic                   ts_we,
  output logic [3:0]             ts_slot,
  output logic [15:0]            ts_value,
  output logic                   irq_rx,
  output logic                   irq_tx,
  output logic                   irq_err,
  output logic                   irq_wake
);

  cst_pkg::cst_slot_t       slot_q [16];
  logic [`CST_MC_W-1:0]     modctl_q;
  logic [15:0]              irqen_q;
  logic [3:0]               mailbox_index_q;
  logic                     rx_succ_q;
  logic                     tx_succ_q;
  logic                     recv_q;
  logic                     xmit_q;
  logic [3:0]               rx_slot_q;
  logic [15:0]              ts_count;
  logic [15:0]              ts_cap;

  logic [15:0] m_rx_data;
  logic [15:0] m_tx_data;
  logic [15:0] m_tx_rem;
  logic [15:0] m_rx_rem;
  logic [15:0] rx_cand;
  logic [15:0] tx_cand;
  logic        rx_found;
  logic [3:0]  rx_idx;
  logic        tx_found;
  logic [3:0]  tx_idx;
  logic        listen_only;
  logic        loopback;
  logic        rx_fire;
  logic        tx_fire;
  logic        tx_end_ok;
  logic        tx_end_lost;
  logic        slot_wr;
  logic        wr_status;

  assign listen_only = modctl_q[`CST_MC_LISTEN];
  assign loopback    = modctl_q[`CST_MC_LOOP];
  assign slot_wr     = bus.wr && (bus.addr <= `CST_A_SLOT_LAST);
  assign wr_status   = bus.wr && (bus.addr == `CST_A_STATUS);

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_mode
      // both requests clear: configuration, no traffic
      assign m_rx_data[i] = slot_q[i].rx_request && !slot_q[i].tx_request
                         && !slot_q[i].remote && !slot_q[i].auto_reply_hold;
      assign m_tx_data[i] = slot_q[i].tx_request && !slot_q[i].rx_request
                         && !slot_q[i].remote && !slot_q[i].auto_reply_hold;
      assign m_tx_rem[i]  = slot_q[i].tx_request && !slot_q[i].rx_request
                         && slot_q[i].remote && !slot_q[i].auto_reply_hold;
      assign m_rx_rem[i]  = slot_q[i].rx_request && !slot_q[i].tx_request
                         && slot_q[i].remote;
      // a remote request still unsent may take the awaited data frame
      assign rx_cand[i] = accept_match[i] && (evt.rx_remote ? m_rx_rem[i]
                         : (m_rx_data[i] || (m_tx_rem[i] && !slot_q[i].tx_in_progress)));
      // held reply slots stay out until software drops the hold
      assign tx_cand[i] = (m_tx_data[i] || m_tx_rem[i])
                         && !slot_q[i].tx_done_flag && !slot_q[i].tx_in_progress;
    end
  endgenerate

  cst_slot_pick u_rx_pick (
    .req   (rx_cand),
    .found (rx_found),
    .idx   (rx_idx)
  );

  cst_slot_pick u_tx_pick (
    .req   (tx_cand),
    .found (tx_found),
    .idx   (tx_idx)
  );

  assign rx_fire = evt.rx_ok && rx_found
                && (!evt.rx_own || loopback);
  assign tx_fire = evt.bus_idle && tx_found && !xmit_q
                && !listen_only;
  assign tx_end_ok   = evt.tx_ok && xmit_q;
  assign tx_end_lost = evt.arb_lost && xmit_q;

  cst_timestamp u_ts (
    .clk      (clk),
    .rst      (rst),
    .bit_tick (evt.bit_tick),
    .div_sel  (modctl_q[`CST_MC_DIV_HI:`CST_MC_DIV_LO]),
    .capture  (rx_fire),
    .count    (ts_count),
    .captured (ts_cap)
  );

  generate
    for (i = 0; i < 16; i++) begin : g_slot
      logic hit_rx;
      logic we;
      logic t_start;
      logic t_ok;
      logic t_lost;
      logic copy_done;

      assign hit_rx    = rx_fire && (rx_idx == 4'(i));
      assign we        = slot_wr && (bus.addr[3:0] == 4'(i));
      assign t_start   = tx_fire && (tx_idx == 4'(i));
      assign t_ok      = tx_end_ok && (tx_slot == 4'(i));
      assign t_lost    = tx_end_lost && (tx_slot == 4'(i));
      assign copy_done = evt.rx_copy_done && (rx_slot_q == 4'(i));

      // hardware updates follow the write so hardware wins over a write in the same cycle
      always_ff @(posedge clk) begin
        if (rst) begin
          slot_q[i] <= '0;
        end else begin
          if (we) begin
            slot_q[i].tx_request      <= bus.wdata[`CST_SL_TXREQ];
            slot_q[i].rx_request      <= bus.wdata[`CST_SL_RXREQ];
            slot_q[i].remote          <= bus.wdata[`CST_SL_REMOTE];
            slot_q[i].auto_reply_hold <= bus.wdata[`CST_SL_HOLD];
            slot_q[i].slot_fresh_flag <= slot_q[i].slot_fresh_flag
                                       && bus.wdata[`CST_SL_FRESH];
            slot_q[i].overwrite_flag  <= slot_q[i].overwrite_flag
                                       && bus.wdata[`CST_SL_OVWR];
            slot_q[i].tx_done_flag    <= slot_q[i].tx_done_flag
                                       && bus.wdata[`CST_SL_DONE];
          end
          if (hit_rx) begin
            slot_q[i].slot_fresh_flag    <= 1'b1;
            slot_q[i].slot_updating_flag <= 1'b1;
            if (slot_q[i].slot_fresh_flag) begin
              slot_q[i].overwrite_flag <= 1'b1;
            end
            if (evt.rx_remote) begin
              slot_q[i].rx_request <= 1'b0;
              slot_q[i].tx_request <= 1'b1;
              slot_q[i].remote     <= 1'b0;
            end else if (m_tx_rem[i]) begin
              slot_q[i].tx_request <= 1'b0;
              slot_q[i].rx_request <= 1'b1;
              slot_q[i].remote     <= 1'b0;
            end
          end
          if (copy_done && !hit_rx) begin
            slot_q[i].slot_updating_flag <= 1'b0;
          end
          if (t_start) begin
            slot_q[i].tx_in_progress <= 1'b1;
          end
          if (t_lost) begin
            slot_q[i].tx_in_progress <= 1'b0;
          end
          if (t_ok) begin
            slot_q[i].tx_in_progress <= 1'b0;
            slot_q[i].tx_done_flag   <= 1'b1;
            if (slot_q[i].remote) begin
              slot_q[i].tx_request <= 1'b0;
              slot_q[i].rx_request <= 1'b1;
              slot_q[i].remote     <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      modctl_q <= `CST_RST_MODCTL;
    end else if (bus.wr && bus.addr == `CST_A_MODCTL) begin
      modctl_q <= bus.wdata[`CST_MC_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqen_q <= `CST_RST_IRQEN;
    end else if (bus.wr && bus.addr == `CST_A_IRQEN) begin
      irqen_q <= bus.wdata;
    end
  end

  // success flags: write 0 clears, a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      mailbox_index_q    <= 4'h0;
      rx_succ_q <= 1'b0;
      tx_succ_q <= 1'b0;
    end else begin
      if (wr_status) begin
        rx_succ_q <= rx_succ_q && bus.wdata[`CST_ST_RX_OK];
        tx_succ_q <= tx_succ_q && bus.wdata[`CST_ST_TX_OK];
      end
      if (rx_fire && irqen_q[rx_idx]) begin
        mailbox_index_q    <= rx_idx;
        rx_succ_q <= 1'b1;
      end
      if (tx_end_ok && irqen_q[tx_slot]) begin
        mailbox_index_q    <= tx_slot;
        tx_succ_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      xmit_q    <= 1'b0;
      tx_slot   <= 4'h0;
      tx_remote <= 1'b0;
      tx_start  <= 1'b0;
    end else begin
      tx_start <= tx_fire;
      if (tx_fire) begin
        xmit_q    <= 1'b1;
        tx_slot   <= tx_idx;
        tx_remote <= m_tx_rem[tx_idx];
      end else if (tx_end_ok || tx_end_lost) begin
        xmit_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      recv_q <= 1'b0;
    end else if (evt.sof_seen && !xmit_q && !tx_found) begin
      recv_q <= 1'b1;
    end else if (tx_end_lost) begin
      recv_q <= 1'b1;
    end else if (evt.bus_idle || tx_fire) begin
      recv_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_slot_q <= 4'h0;
      ts_we     <= 1'b0;
      ts_slot   <= 4'h0;
      ts_value  <= 16'h0000;
    end else begin
      ts_we <= evt.rx_copy_done;
      if (rx_fire) begin
        rx_slot_q <= rx_idx;
      end
      if (evt.rx_copy_done) begin
        ts_slot  <= rx_slot_q;
        ts_value <= ts_cap;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_rx   <= 1'b0;
      irq_tx   <= 1'b0;
      irq_err  <= 1'b0;
      irq_wake <= 1'b0;
    end else begin
      irq_rx   <= rx_fire && irqen_q[rx_idx];
      irq_tx   <= tx_end_ok && irqen_q[tx_slot];
      irq_err  <= evt.err_passive || evt.bus_off
               || (evt.bus_err && modctl_q[`CST_MC_BERR_EN]);
      irq_wake <= evt.wake;
    end
  end

  // listen-only silences frames, error frames and ack alike
  assign drive_enable = !listen_only;
  assign ack_enable   = !listen_only && !loopback;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (!bus.rd) begin
      rdata <= 16'h0000;
    end else if (bus.addr <= `CST_A_SLOT_LAST) begin
      rdata <= {6'h00,
                slot_q[bus.addr[3:0]].tx_request,
                slot_q[bus.addr[3:0]].rx_request,
                slot_q[bus.addr[3:0]].remote,
                slot_q[bus.addr[3:0]].auto_reply_hold,
                slot_q[bus.addr[3:0]].remote
                  && (slot_q[bus.addr[3:0]].tx_request
                  ^ slot_q[bus.addr[3:0]].rx_request),
                slot_q[bus.addr[3:0]].tx_in_progress,
                slot_q[bus.addr[3:0]].tx_done_flag,
                slot_q[bus.addr[3:0]].overwrite_flag,
                slot_q[bus.addr[3:0]].slot_updating_flag,
                slot_q[bus.addr[3:0]].slot_fresh_flag};
    end else if (bus.addr == `CST_A_MODCTL) begin
      rdata <= {11'h000, modctl_q};
    end else if (bus.addr == `CST_A_STATUS) begin
      rdata <= {8'h00, xmit_q, recv_q, tx_succ_q, rx_succ_q, mailbox_index_q};
    end else if (bus.addr == `CST_A_IRQEN) begin
      rdata <= irqen_q;
    end else if (bus.addr == `CST_A_TSTAMP) begin
      rdata <= ts_count;
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule : cst_slot_ctrl

/* cst_props.sv */
`timescale 1ns/1ps

module cst_props (
  input wire logic              clk,
  input wire logic              rst,
  input wire cst_pkg::cst_bus_t bus,
  input wire logic [15:0]       rdata,
  input wire cst_pkg::cst_evt_t evt,
  input wire logic [15:0]       accept_match,
  input wire logic              tx_start,
  input wire logic [3:0]        tx_slot,
  input wire logic              tx_remote,
  input wire logic              drive_enable,
  input wire logic              ack_enable,
  input wire logic              ts_we,
  input wire logic [3:0]        ts_slot,
  input wire logic [15:0]       ts_value,
  input wire logic              irq_rx,
  input wire logic              irq_tx,
  input wire logic              irq_err,
  input wire logic              irq_wake
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_rdata_quiet: assert property (!bus.rd |=> rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_start_drives: assert property (tx_start |-> drive_enable)
    else $error("transmit start while bus driving is off");
  a_ack_drives: assert property (ack_enable |-> drive_enable)
    else $error("acknowledge enabled while bus driving is off");
  a_start_pulse: assert property (tx_start |=> !tx_start)
    else $error("transmit start longer than one cycle");
  a_stamp_write: assert property (ts_we |-> $past(evt.rx_copy_done))
    else $error("stamp store without a finished copy");
  a_rx_irq: assert property (irq_rx |-> $past(evt.rx_ok))
    else $error("receive interrupt without a reception");
  a_tx_irq: assert property (irq_tx |-> $past(evt.tx_ok))
    else $error("transmit interrupt without a transmission");
  a_err_irq: assert property ((evt.err_passive || evt.bus_off) |=> irq_err)
    else $error("error state change gave no interrupt");
  a_wake_irq: assert property (evt.wake |=> irq_wake)
    else $error("wake event gave no interrupt");
  a_err_cause: assert property (irq_err |-> $past(evt.err_passive) ||
    $past(evt.bus_off) || $past(evt.bus_err)) else $error("error interrupt without cause");
endmodule : cst_props

bind cst_slot_ctrl cst_props u_props (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .evt(evt), .accept_match(accept_match), .tx_start(tx_start), .tx_slot(tx_slot),
  .tx_remote(tx_remote), .drive_enable(drive_enable), .ack_enable(ack_enable),
  .ts_we(ts_we), .ts_slot(ts_slot), .ts_value(ts_value), .irq_rx(irq_rx),
  .irq_tx(irq_tx), .irq_err(irq_err), .irq_wake(irq_wake));

/* cst_bus_model.sv */
`timescale 1ns/1ps

module cst_bus_model (
  input  wire logic         clk,
  input  wire logic         tx_start,
  output cst_pkg::cst_evt_t evt,
  output logic [15:0]       accept_match
);
  logic [1:0] tick_q;
  logic       busy_q;
  logic       rxb_q;
  logic       lose_q;
  int         gap_q;
  int         wait_q;

  initial begin
    evt = '0;
    accept_match = 16'h0000;
    tick_q = 2'h0;
    busy_q = 1'b0;
    rxb_q = 1'b0;
    lose_q = 1'b0;
    gap_q = 3;
  end

  // bit time of four clocks keeps stamp checks short
  always @(posedge clk) begin
    tick_q <= tick_q + 2'h1;
    evt.bit_tick <= (tick_q == 2'h3);
    evt.tx_ok <= 1'b0;
    evt.arb_lost <= 1'b0;
    evt.bus_idle <= !busy_q && !rxb_q && !tx_start;
    if (tx_start) begin
      busy_q <= 1'b1;
      wait_q <= gap_q;
    end else if (busy_q && wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      evt.tx_ok <= !lose_q;
      evt.arb_lost <= lose_q;
      lose_q <= 1'b0;
    end
  end

  task automatic frame(input logic [15:0] m, input logic rem, input logic own);
    @(posedge clk);
    rxb_q <= 1'b1;
    evt.sof_seen <= 1'b1;
    @(posedge clk);
    evt.sof_seen <= 1'b0;
    repeat (4) @(posedge clk);
    evt.rx_ok <= 1'b1;
    evt.rx_remote <= rem;
    evt.rx_own <= own;
    accept_match <= m;
    @(posedge clk);
    // qualifiers turn to garbage once the strobe is gone
    evt.rx_ok <= 1'b0;
    evt.rx_remote <= !rem;
    evt.rx_own <= !own;
    accept_match <= ~m;
    repeat (2) @(posedge clk);
    evt.rx_copy_done <= 1'b1;
    @(posedge clk);
    evt.rx_copy_done <= 1'b0;
    rxb_q <= 1'b0;
  endtask : frame

  task automatic ev(input logic [3:0] k);
    @(posedge clk);
    {evt.err_passive, evt.bus_off, evt.bus_err, evt.wake} <= k;
    @(posedge clk);
    {evt.err_passive, evt.bus_off, evt.bus_err, evt.wake} <= 4'h0;
  endtask : ev
endmodule : cst_bus_model

/* tb_can_slot_txrx_timestamp.sv */
`timescale 1ns/1ps

module tb_can_slot_txrx_timestamp;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  cst_pkg::cst_bus_t bus = '0;
  cst_pkg::cst_evt_t evt;
  logic [15:0]       accept_match, rdata, ts_value, a, b;
  logic [3:0]        tx_slot, ts_slot, last_slot, ts_q;
  logic              tx_start, tx_remote, drive_enable, ack_enable, ts_we;
  logic              irq_rx, irq_tx, irq_err, irq_wake, last_rem;
  int                n_fail = 0;
  int                compares = 0;
  int                n_irx = 0, n_itx = 0, n_ie = 0, n_iw = 0, n_st = 0;

  always #2 clk = ~clk;

  cst_slot_ctrl dut_u (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .evt(evt),
    .accept_match(accept_match), .tx_start(tx_start), .tx_slot(tx_slot),
    .tx_remote(tx_remote), .drive_enable(drive_enable), .ack_enable(ack_enable),
    .ts_we(ts_we), .ts_slot(ts_slot), .ts_value(ts_value), .irq_rx(irq_rx),
    .irq_tx(irq_tx), .irq_err(irq_err), .irq_wake(irq_wake));
  cst_bus_model u_bus (.clk(clk), .tx_start(tx_start), .evt(evt), .accept_match(accept_match));

  always @(posedge clk) begin
    if (irq_rx === 1'b1) n_irx <= n_irx + 1;
    if (irq_tx === 1'b1) n_itx <= n_itx + 1;
    if (irq_err === 1'b1) n_ie <= n_ie + 1;
    if (irq_wake === 1'b1) n_iw <= n_iw + 1;
    if (ts_we === 1'b1) ts_q <= ts_slot;
    if (tx_start === 1'b1) begin
      n_st <= n_st + 1;
      last_slot <= tx_slot;
      last_rem <= tx_remote;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= ad;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [15:0] d);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= ad;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd

  // a timeout here (200 clocks) means a transfer never finished; the bench counts a failure and stops
  task automatic wait_cnt(ref int c, input int v);
    for (int i = 0; i < 200 && c < v; i++)
      @(posedge clk);
    if (c < v) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_cnt

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(8'h10, 16'(k << 2));
      repeat (40) @(posedge clk);
      rd(8'h13, a);
      repeat (62) @(posedge clk);
      rd(8'h13, b);
      chk(b - a, 16'(16'h0010 >> k));
    end
    wr(8'h20, 16'hFFFF);
    rd(8'h20, a);
    chk(a, 16'h0000);
    wr(8'h02, 16'h0000);
    wr(8'h05, 16'h0000);
    wr(8'h02, 16'h0100);
    wr(8'h05, 16'h0100);
    wr(8'h12, 16'h0024);
    // stamp ticks every 32 clocks here, frame takes 7: at most one step
    rd(8'h13, b);
    u_bus.frame(16'h0024, 1'b0, 1'b0);
    rd(8'h02, a);
    chk(a, 16'h0101);
    rd(8'h05, a);
    chk(a, 16'h0100);
    rd(8'h11, a);
    chk(a & 16'h003F, 16'h0012);
    chk({12'h000, ts_q}, 16'h0002);
    chk(16'(ts_value - b) & 16'hFFFE, 16'h0000);
    // status read while the second frame is still on the bus
    fork
      u_bus.frame(16'h0024, 1'b0, 1'b0);
      begin
        repeat (3) @(posedge clk);
        rd(8'h11, b);
      end
    join
    chk(b & 16'h00C0, 16'h0040);
    rd(8'h02, a);
    chk(a, 16'h0105);
    chk(16'(n_irx), 16'h0002);
    wr(8'h02, 16'h0100);
    u_bus.frame(16'h0004, 1'b0, 1'b1);
    rd(8'h02, a);
    chk(a, 16'h0100);
    wr(8'h10, 16'h0002);
    @(negedge clk);
    chk({14'h0000, drive_enable, ack_enable}, 16'h0002);
    u_bus.frame(16'h0004, 1'b0, 1'b1);
    rd(8'h02, a);
    chk(a, 16'h0101);
    wr(8'h10, 16'h0001);
    @(negedge clk);
    chk({14'h0000, drive_enable, ack_enable}, 16'h0000);
    wr(8'h10, 16'h0000);
    wr(8'h12, 16'h0D80);
    wr(8'h07, 16'h0200);
    wait_cnt(n_itx, 1);
    chk({12'h000, last_slot}, 16'h0007);
    rd(8'h07, a);
    chk(a, 16'h0208);
    rd(8'h11, a);
    chk(a & 16'h00AF, 16'h0027);
    u_bus.lose_q <= 1'b1;
    u_bus.gap_q <= 0;
    wr(8'h08, 16'h0200);
    wait_cnt(n_itx, 2);
    chk(16'(n_st), 16'h0003);
    u_bus.gap_q <= 6;
    wr(8'h0A, 16'h0280);
    rd(8'h0A, a);
    chk(a & 16'h0030, 16'h0030);
    rd(8'h11, a);
    chk(a & 16'h0080, 16'h0080);
    wait_cnt(n_itx, 3);
    chk({15'h0000, last_rem}, 16'h0001);
    rd(8'h0A, a);
    chk(a & 16'h03E0, 16'h0100);
    wr(8'h0B, 16'h01C0);
    rd(8'h0B, a);
    chk(a & 16'h03E0, 16'h01E0);
    u_bus.frame(16'h0800, 1'b1, 1'b0);
    rd(8'h0B, a);
    chk(a & 16'h03E0, 16'h0240);
    chk(16'(n_st), 16'h0004);
    wr(8'h0B, 16'h0200);
    wait_cnt(n_itx, 4);
    chk({12'h000, last_slot}, 16'h000B);
    wr(8'h07, 16'h0000);
    rd(8'h07, a);
    chk(a, 16'h0000);
    wr(8'h07, 16'h0200);
    wait_cnt(n_itx, 5);
    chk({12'h000, last_slot}, 16'h0007);
    u_bus.ev(4'h8);
    u_bus.ev(4'h4);
    u_bus.ev(4'h2);
    wr(8'h10, 16'h0010);
    u_bus.ev(4'h2);
    u_bus.ev(4'h1);
    repeat (2) @(posedge clk);
    chk(16'(n_ie), 16'h0003);
    chk(16'(n_iw), 16'h0001);
    report_and_stop();
  end
endmodule : tb_can_slot_txrx_timestamp
